// ---- hdl/ies_pkg.sv ----
// package: constants and types shared by the interrupt entry/exit sequencer
// Behaviour
// - core logic runs straight on pclk, no internal clock divider.
// - two-register alu op reads, computes and writes back in one cycle.
// - reset and each source own distinct vectors; source needs own and global enable.
// - lowest vector address wins; reset highest, source zero next.
// - accepting an interrupt clears the global enable bit.
// - global enable set inside a handler lets enabled requests nest.
// - return-from-handler op sets the global enable bit.
// - a flag source's pending flag is cleared by hardware when vectored.
// - writing one to a flag position clears it; zero leaves it.
// - events set flags even while disabled; flag holds until served or cleared.
// - flags raised with global enable off stay pending, then served by priority.
// - level sources request only while their condition is present.
// - after return, one interrupted instruction runs before another entry.
// - flags register is neither saved on entry nor restored on return.
// - global-disable op blocks any entry at once, even same cycle.
// - after global-enable op the next instruction runs before any entry.
// - entry takes four cycles, pushing the pc, then the vector runs.
// - the jump at the vector takes three cycles to reach the handler.
// - entry waits until a multi-cycle instruction has completed.
// - waking from sleep adds four cycles to the entry.
// - return takes four cycles, pops two pc bytes, stack pointer plus two.
// - stack grows down; entry push lowers the stack pointer by two.
// - global enable is flags register bit 7, software sets and clears it.
package ies_pkg;

  // ****************************************************************
  // sources
  // ****************************************************************
  localparam int NUM_FLAG  = 4;
  localparam int NUM_LEVEL = 2;
  localparam int NUM_SRC   = NUM_FLAG + NUM_LEVEL;
  localparam int SRC_W     = 3;
  localparam int CNT_W     = 3;

  // ****************************************************************
  // flags register layout
  // ****************************************************************
  localparam int FLAG_C   = 0;
  localparam int FLAG_Z   = 1;
  localparam int FLAG_N   = 2;
  localparam int FLAG_V   = 3;
  localparam int FLAG_S   = 4;
  localparam int FLAG_H   = 5;
  localparam int FLAG_GIE = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ****************************************************************
  // timing in pclk cycles
  // ****************************************************************
  localparam logic [CNT_W-1:0] ENTRY_CYC  = 3'h4;
  localparam logic [CNT_W-1:0] JUMP_CYC   = 3'h3;
  localparam logic [CNT_W-1:0] WAKE_CYC   = 3'h4;
  localparam logic [CNT_W-1:0] RETURN_CYC = 3'h4;

  // ****************************************************************
  // vectors and stack
  // ****************************************************************
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_STEP     = 16'h0002;
  localparam logic [15:0] SP_RESET     = 16'h02ff;
  localparam logic [15:0] SP_STEP      = 16'h0001;

  // ****************************************************************
  // apb register map, byte addresses
  // ****************************************************************
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_FLAGS   = 12'h000;
  localparam logic [11:0] ADDR_ENABLE  = 12'h004;
  localparam logic [11:0] ADDR_PENDING = 12'h008;
  localparam logic [11:0] ADDR_SP      = 12'h00c;
  localparam logic [11:0] ADDR_STATUS  = 12'h010;
  localparam logic [11:0] ADDR_HANDLER = 12'h020;
  localparam logic [11:0] ADDR_STRIDE  = 12'h004;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    IES_OP_OTHER, IES_OP_ALU, IES_OP_SEI, IES_OP_CLI, IES_OP_RETURN_FROM_HANDLER_OP
  } ies_op_t;

  typedef enum logic [2:0] {
    IES_ALU_ADD, IES_ALU_SUB, IES_ALU_AND, IES_ALU_OR, IES_ALU_EOR, IES_ALU_MOV
  } ies_alu_t;

  typedef enum logic [2:0] {
    IES_RUN, IES_WAKE, IES_ENTRY, IES_JUMP, IES_RETURN
  } ies_state_t;

endpackage

// ---- hdl/ies_flag_unit.sv ----
// pending flags of the flag-type interrupt sources
`timescale 1ns/1ps
module ies_flag_unit
  import ies_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // events and clears
  input  wire logic [NUM_FLAG-1:0] flag_evt,
  input  wire logic                sw_clr_en,
  input  wire logic [NUM_FLAG-1:0] sw_clr_data,
  input  wire logic [NUM_FLAG-1:0] hw_clr,
  // state
  output logic      [NUM_FLAG-1:0] flags
);

  typedef struct packed {
    logic [NUM_FLAG-1:0] pend;
  } ies_flag_st_t;

  ies_flag_st_t st_reg;
  ies_flag_st_t st_next;

  // ****************************************************************
  // set wins over either clear so no event is lost
  // ****************************************************************
  always_comb begin
    logic [NUM_FLAG-1:0] clr;
    clr = hw_clr;
    if (sw_clr_en) begin
      clr = clr | sw_clr_data;
    end
    st_next.pend = (st_reg.pend & ~clr) | flag_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.pend;

endmodule

// ---- hdl/ies_alu.sv ----
// register file with single-cycle two-operand alu
`timescale 1ns/1ps
module ies_alu
  import ies_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // operation
  input  wire logic       alu_valid,
  input  wire ies_alu_t   alu_func,
  input  wire logic [4:0] alu_rd,
  input  wire logic [4:0] alu_rr,
  // flags
  input  wire logic [7:0] flags_in,
  output logic      [7:0] flags_out,
  output logic      [7:0] alu_result
);

  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [7:0]       result;
  } ies_alu_st_t;

  ies_alu_st_t st_reg;
  ies_alu_st_t st_next;

  always_comb begin
    logic [7:0] a;
    logic [7:0] b;
    logic [8:0] r;
    a = st_reg.regs[alu_rd];
    b = st_reg.regs[alu_rr];
    r = '0;
    flags_out = flags_in;
    st_next = st_reg;
    case (alu_func)
      IES_ALU_ADD: begin
        r = {1'b0, a} + {1'b0, b};
        flags_out[FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
        flags_out[FLAG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        flags_out[FLAG_C] = r[8];
      end
      IES_ALU_SUB: begin
        r = {1'b0, a} - {1'b0, b};
        flags_out[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        flags_out[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        flags_out[FLAG_C] = r[8];
      end
      IES_ALU_AND: begin
        r = {1'b0, a & b};
        flags_out[FLAG_V] = 1'b0;
      end
      IES_ALU_OR: begin
        r = {1'b0, a | b};
        flags_out[FLAG_V] = 1'b0;
      end
      IES_ALU_EOR: begin
        r = {1'b0, a ^ b};
        flags_out[FLAG_V] = 1'b0;
      end
      default: begin
        r = {1'b0, b};
      end
    endcase
    // move leaves the flags alone
    if (alu_func != IES_ALU_MOV) begin
      flags_out[FLAG_N] = r[7];
      flags_out[FLAG_Z] = (r[7:0] == 8'h00);
      flags_out[FLAG_S] = r[7] ^ flags_out[FLAG_V];
    end
    if (alu_valid) begin
      st_next.regs[alu_rd] = r[7:0];
      st_next.result       = r[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign alu_result = st_reg.result;

endmodule

// ---- hdl/ies_irq_seq.sv ----
// interrupt entry/exit sequencer with apb control registers
`timescale 1ns/1ps
module ies_irq_seq
  import ies_pkg::*;
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // interrupt sources
  input  wire logic [NUM_FLAG-1:0]  flag_evt,
  input  wire logic [NUM_LEVEL-1:0] level_req,
  // core execution
  input  wire logic                 instr_retire,
  input  wire ies_op_t              instr_op,
  input  wire logic [15:0]          instr_next_pc,
  input  wire logic                 core_sleep,
  input  wire ies_alu_t             alu_func,
  input  wire logic [4:0]           alu_rd,
  input  wire logic [4:0]           alu_rr,
  // core control
  output logic                      core_hold,
  output logic                      pc_load,
  output logic      [15:0]          pc_value,
  output logic                      gie,
  output logic      [7:0]           flags_register,
  output logic      [7:0]           alu_result,
  // stack memory
  output logic                      mem_we,
  output logic                      mem_re,
  output logic      [15:0]          mem_addr,
  output logic      [7:0]           mem_wdata,
  input  wire logic [7:0]           mem_rdata
);

  typedef struct packed {
    ies_state_t                  state;
    logic [CNT_W-1:0]            cnt;
    logic [7:0]                  flags_reg;
    logic [15:0]                 sp;
    logic [NUM_FLAG-1:0]         flag_en;
    logic [NUM_LEVEL-1:0]        level_en;
    logic                        guard;
    logic [SRC_W-1:0]            src;
    logic [15:0]                 ret_pc;
    logic [7:0]                  pop_hi;
    logic [NUM_SRC-1:0][15:0]    handler;
    logic                        pc_load;
    logic [15:0]                 pc_value;
    logic                        mem_we;
    logic                        mem_re;
    logic [15:0]                 mem_addr;
    logic [7:0]                  mem_wdata;
    logic [31:0]                 prdata;
    logic                        pslverr;
  } ies_seq_st_t;

  ies_seq_st_t           st_reg;
  ies_seq_st_t           st_next;
  logic [NUM_FLAG-1:0]   flags;
  logic [NUM_FLAG-1:0]   hw_clr;
  logic                  sw_clr_en;
  logic [7:0]            alu_flags;
  logic                  alu_valid;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // lowest index is lowest vector address, so highest priority
  function automatic logic [SRC_W-1:0] pick_src(input logic [NUM_SRC-1:0] req);
    logic [SRC_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction

  // reset owns vector zero, each source the slot after it
  function automatic logic [15:0] vector_of(input logic [SRC_W-1:0] s);
    return RESET_VECTOR + VEC_STEP * (16'(s) + 16'h0001);
  endfunction

  // handler slot decode, shared by read and write paths
  function automatic logic hit_handler(input logic [ADDR_W-1:0] a,
                                       output logic [SRC_W-1:0] idx);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_HANDLER;
    idx = SRC_W'(off / ADDR_STRIDE);
    return (a >= ADDR_HANDLER) && (off[1:0] == 2'b00) &&
           (off < ADDR_W'(NUM_SRC) * ADDR_STRIDE);
  endfunction

  // ****************************************************************
  // sub blocks
  // ****************************************************************
  ies_flag_unit u_flags (
    .pclk        (pclk),
    .presetn     (presetn),
    .flag_evt    (flag_evt),
    .sw_clr_en   (sw_clr_en),
    .sw_clr_data (pwdata[NUM_FLAG-1:0]),
    .hw_clr      (hw_clr),
    .flags       (flags)
  );

  assign alu_valid = instr_retire && (instr_op == IES_OP_ALU) && (st_reg.state == IES_RUN);

  ies_alu u_alu (
    .pclk       (pclk),
    .presetn    (presetn),
    .alu_valid  (alu_valid),
    .alu_func   (alu_func),
    .alu_rd     (alu_rd),
    .alu_rr     (alu_rr),
    .flags_in   (st_reg.flags_reg),
    .flags_out  (alu_flags),
    .alu_result (alu_result)
  );

  // ****************************************************************
  // apb write strobes
  // ****************************************************************
  logic                 apb_wr;
  logic                 apb_setup;
  logic                 hit_h;
  logic [SRC_W-1:0]     h_idx;

  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign sw_clr_en = apb_wr && (paddr == ADDR_PENDING);

  always_comb begin
    h_idx = '0;
    hit_h = hit_handler(paddr, h_idx);
  end

  // ****************************************************************
  // request and acceptance
  // ****************************************************************
  logic [NUM_SRC-1:0]   req;
  logic                 req_any;
  logic                 gie_eff;
  logic                 boundary;
  logic                 take;

  always_comb begin
    // level sources ask only while their condition stands
    req     = {level_req & st_reg.level_en, flags & st_reg.flag_en};
    req_any = |req;
    // global disable op closes the gate in its own cycle
    gie_eff = st_reg.flags_reg[FLAG_GIE] &&
              !(instr_retire && instr_op == IES_OP_CLI);
    // retire marks a completed instruction, even a multi-cycle one
    boundary = (instr_retire && instr_op != IES_OP_SEI &&
                instr_op != IES_OP_RETURN_FROM_HANDLER_OP) ||
               (core_sleep && !st_reg.guard);
    take = (st_reg.state == IES_RUN) && gie_eff && req_any && boundary;
  end

  // ****************************************************************
  // sequencer and registers
  // ****************************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.pc_load = 1'b0;
    st_next.mem_we  = 1'b0;
    st_next.mem_re  = 1'b0;
    hw_clr          = '0;

    // software side first, the sequence below overrides it
    if (apb_wr) begin
      case (paddr)
        ADDR_FLAGS:  st_next.flags_reg = pwdata[7:0];
        ADDR_ENABLE: begin
          st_next.flag_en  = pwdata[NUM_FLAG-1:0];
          st_next.level_en = pwdata[NUM_SRC-1:NUM_FLAG];
        end
        ADDR_SP:     st_next.sp = pwdata[15:0];
        default: begin
          if (hit_h) begin
            st_next.handler[h_idx] = pwdata[15:0];
          end
        end
      endcase
    end
    if (alu_valid) begin
      st_next.flags_reg[FLAG_H:FLAG_C] = alu_flags[FLAG_H:FLAG_C];
    end
    if (instr_retire && st_reg.state == IES_RUN) begin
      st_next.guard = 1'b0;
      if (instr_op == IES_OP_SEI) begin
        st_next.flags_reg[FLAG_GIE] = 1'b1;
        st_next.guard               = 1'b1;
      end else if (instr_op == IES_OP_CLI) begin
        st_next.flags_reg[FLAG_GIE] = 1'b0;
      end
    end

    case (st_reg.state)
      IES_RUN: begin
        if (instr_retire && instr_op == IES_OP_RETURN_FROM_HANDLER_OP) begin
          st_next.state    = IES_RETURN;
          st_next.cnt      = '0;
          st_next.mem_re   = 1'b1;
          st_next.mem_addr = st_reg.sp + SP_STEP;
        end else if (take) begin
          st_next.src                 = pick_src(req);
          st_next.ret_pc              = instr_next_pc;
          st_next.flags_reg[FLAG_GIE] = 1'b0;
          st_next.cnt                 = '0;
          if (core_sleep && !instr_retire) begin
            st_next.state = IES_WAKE;
          end else begin
            st_next.state     = IES_ENTRY;
            st_next.mem_we    = 1'b1;
            st_next.mem_addr  = st_reg.sp;
            st_next.mem_wdata = instr_next_pc[7:0];
          end
        end
      end
      IES_WAKE: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == WAKE_CYC - 1'b1) begin
          st_next.state     = IES_ENTRY;
          st_next.cnt       = '0;
          st_next.mem_we    = 1'b1;
          st_next.mem_addr  = st_reg.sp;
          st_next.mem_wdata = st_reg.ret_pc[7:0];
        end
      end
      IES_ENTRY: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == '0) begin
          // high byte below the low byte; stack grows downward
          st_next.mem_we    = 1'b1;
          st_next.mem_addr  = st_reg.sp - SP_STEP;
          st_next.mem_wdata = st_reg.ret_pc[15:8];
        end
        if (st_reg.cnt == ENTRY_CYC - 3'h2) begin
          st_next.pc_load  = 1'b1;
          st_next.pc_value = vector_of(st_reg.src);
          st_next.sp       = st_reg.sp - (SP_STEP + SP_STEP);
          if (32'(st_reg.src) < NUM_FLAG) begin
            hw_clr[st_reg.src[1:0]] = 1'b1;
          end
        end
        if (st_reg.cnt == ENTRY_CYC - 1'b1) begin
          st_next.state = IES_JUMP;
          st_next.cnt   = '0;
        end
      end
      IES_JUMP: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == JUMP_CYC - 3'h2) begin
          st_next.pc_load  = 1'b1;
          st_next.pc_value = st_reg.handler[st_reg.src];
        end
        if (st_reg.cnt == JUMP_CYC - 1'b1) begin
          st_next.state = IES_RUN;
        end
      end
      IES_RETURN: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == '0) begin
          st_next.mem_re   = 1'b1;
          st_next.mem_addr = st_reg.sp + (SP_STEP + SP_STEP);
        end
        if (st_reg.cnt == 3'h1) begin
          st_next.pop_hi = mem_rdata;
        end
        if (st_reg.cnt == RETURN_CYC - 3'h2) begin
          st_next.pc_load             = 1'b1;
          st_next.pc_value            = {st_reg.pop_hi, mem_rdata};
          st_next.sp                  = st_reg.sp + (SP_STEP + SP_STEP);
          st_next.flags_reg[FLAG_GIE] = 1'b1;
        end
        if (st_reg.cnt == RETURN_CYC - 1'b1) begin
          // one interrupted instruction must retire before the next entry
          st_next.state = IES_RUN;
          st_next.guard = 1'b1;
        end
      end
      default: begin
        st_next.state = IES_RUN;
      end
    endcase
    // the low flags are left untouched by entry and return
    // software keeps them if a handler needs them

    // read data is latched in setup so the access phase is zero wait
    if (apb_setup) begin
      st_next.pslverr = 1'b0;
      st_next.prdata  = '0;
      case (paddr)
        ADDR_FLAGS:   st_next.prdata[7:0] = st_reg.flags_reg;
        ADDR_ENABLE:  st_next.prdata[NUM_SRC-1:0] = {st_reg.level_en, st_reg.flag_en};
        ADDR_PENDING: st_next.prdata[NUM_SRC-1:0] = {level_req, flags};
        ADDR_SP:      st_next.prdata[15:0] = st_reg.sp;
        ADDR_STATUS:  st_next.prdata[SRC_W+1:0] = {st_reg.src, st_reg.guard,
                                                   st_reg.state != IES_RUN};
        default: begin
          if (hit_h) begin
            st_next.prdata[15:0] = st_reg.handler[h_idx];
          end else begin
            st_next.pslverr = 1'b1;
          end
        end
      endcase
    end
  end

  // single undivided clock for all sequencing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg           <= '0;
      st_reg.state     <= IES_RUN;
      st_reg.flags_reg <= FLAGS_RESET;
      st_reg.sp        <= SP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata         = st_reg.prdata;
  assign pready         = 1'b1;
  assign pslverr        = st_reg.pslverr;
  assign core_hold      = (st_reg.state != IES_RUN);
  assign pc_load        = st_reg.pc_load;
  assign pc_value       = st_reg.pc_value;
  assign gie            = st_reg.flags_reg[FLAG_GIE];
  assign flags_register = st_reg.flags_reg;
  assign mem_we         = st_reg.mem_we;
  assign mem_re         = st_reg.mem_re;
  assign mem_addr       = st_reg.mem_addr;
  assign mem_wdata      = st_reg.mem_wdata;

endmodule

// ---- verification/ies_checker.sv ----
// assertions on the sequencer ports
`timescale 1ns/1ps
module ies_checker
  import ies_pkg::*;
(
  // watched ports
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        instr_retire,
  input wire ies_op_t     instr_op,
  input wire logic [15:0] instr_next_pc,
  input wire logic        core_sleep,
  input wire logic        core_hold,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value,
  input wire logic        gie,
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_push; $rose(core_hold) && mem_we; endsequence
  sequence s_ret; instr_retire && instr_op == IES_OP_RETURN_FROM_HANDLER_OP && !core_hold; endsequence
  property p_gie; s_push |-> !gie; endproperty
  a_gie: assert property (p_gie) else $error("gie kept");
  property p_push; s_push |-> mem_wdata == ($past(instr_next_pc) & 16'hff) ##1 mem_we &&
    mem_wdata == ($past(instr_next_pc, 2) >> 8) && mem_addr == $past(mem_addr) - 16'h1;
  endproperty
  a_push: assert property (p_push) else $error("bad push");
  property p_entry;
    s_push |-> ##3 pc_load && pc_value <= 16'hc ##1 core_hold [*3] ##1 !core_hold;
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry");
  property p_ret; s_ret |=> mem_re ##1 mem_re && mem_addr == $past(mem_addr) + 16'h1
    ##2 pc_load && core_hold ##1 !core_hold && gie; endproperty
  a_ret: assert property (p_ret) else $error("bad return");
  property p_cli;
    instr_retire && instr_op == IES_OP_CLI && !core_hold |=> !gie && !core_hold;
  endproperty
  a_cli: assert property (p_cli) else $error("entry after disable");
  property p_sei;
    instr_retire && instr_op == IES_OP_SEI && !core_hold |=> gie && !core_hold;
  endproperty
  a_sei: assert property (p_sei) else $error("bad enable");
  property p_cause; $rose(core_hold) |-> $past(instr_retire) || $past(core_sleep); endproperty
  a_cause: assert property (p_cause) else $error("entry mid instr");
  property p_guard; $fell(core_hold) && core_sleep && !instr_retire |=> !core_hold; endproperty
  a_guard: assert property (p_guard) else $error("no instr ran");
endmodule
bind ies_irq_seq ies_checker u_ies_checker (.pclk, .presetn, .instr_retire, .instr_op,
  .instr_next_pc, .core_sleep, .core_hold, .pc_load, .pc_value, .gie, .mem_we, .mem_re,
  .mem_addr, .mem_wdata);

// ---- verification/ies_stack_mem.sv ----
// stack memory model, read data one cycle after the request
`timescale 1ns/1ps
module ies_stack_mem (
  // stack port
  input  wire logic        pclk,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] m [0:1023];
  initial mem_rdata = 8'h00;
  // data toggles outside a read so a late sample cannot pass
  always @(posedge pclk) begin
    if (mem_we) m[mem_addr[9:0]] <= mem_wdata;
    mem_rdata <= mem_re ? m[mem_addr[9:0]] : ~mem_rdata;
  end
endmodule

// ---- verification/cpu_interrupt_entry_exit_sequencer_tb.sv ----
// bench for the interrupt entry/exit sequencer
`timescale 1ns/1ps
module cpu_interrupt_entry_exit_sequencer_tb;
  import ies_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_retire = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  flag_evt = 0;
  logic [1:0]  level_req = 0;
  logic [15:0] instr_next_pc = 0, pc_value, mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, flags_q, alu_q;
  logic        pready, pslverr, core_hold, pc_load, gie, mem_we, mem_re, core_sleep = 0;
  ies_op_t     instr_op = IES_OP_OTHER;
  int          miscompares = 0, check_count = 0, cyc = 0;
  always #5 pclk = ~pclk;
  ies_irq_seq u_ies_irq_seq (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .flag_evt, .level_req, .instr_retire, .instr_op,
    .instr_next_pc, .core_sleep, .alu_func(IES_ALU_ADD), .alu_rd(5'h00),
    .alu_rr(5'h01), .core_hold, .pc_load, .pc_value, .gie, .flags_register(flags_q),
    .alu_result(alu_q), .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata);
  ies_stack_mem u_ies_stack_mem (.pclk, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata);
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic ret(input ies_op_t op, input logic [15:0] pc);
    @(posedge pclk) {instr_retire, instr_op, instr_next_pc} <= {1'b1, op, pc};
    @(posedge pclk) instr_retire <= 0;
  endtask
  task automatic wpc(input logic [15:0] exp);
    @(posedge pclk);
    for (int n = 0; n < 30 && pc_load !== 1'b1; n++) @(posedge pclk);
    chk(pc_value, exp);
  endtask
  task automatic pulse(input logic [3:0] f, input logic [1:0] l);
    @(posedge pclk) {flag_evt, level_req} <= {f, l};
    @(posedge pclk) flag_evt <= 0;
  endtask
  task automatic t_flags;
    pulse(4'h4, 2'b00);
    apb(0, ADDR_PENDING, 0); chk(rd, 32'h4);
    apb(1, ADDR_PENDING, 0); apb(0, ADDR_PENDING, 0); chk(rd, 32'h4);
    apb(1, ADDR_PENDING, 4); apb(0, ADDR_PENDING, 0); chk(rd, 32'h0);
    apb(0, 12'h014, 0); chk({rd[30:0], pslverr}, 32'h1);
  endtask
  task automatic t_nest;
    apb(1, ADDR_ENABLE, 32'hf);
    for (int i = 0; i < 6; i++) apb(1, ADDR_HANDLER + 12'(4 * i), 32'h100 + i);
    apb(1, ADDR_FLAGS, 32'h03);
    pulse(4'ha, 2'b00);
    ret(IES_OP_OTHER, 16'h1000);
    @(posedge pclk) chk(core_hold, 0);
    ret(IES_OP_SEI, 16'h1002);
    ret(IES_OP_OTHER, 16'h1234);
    wpc(16'h0004);
    wpc(16'h0101);
    apb(0, ADDR_FLAGS, 0); chk(rd, 32'h03);
    apb(0, ADDR_PENDING, 0); chk(rd, 32'h8);
    apb(0, ADDR_SP, 0); chk(rd, 32'h2fd);
    chk(u_ies_stack_mem.m[10'h2ff], 8'h34);
    chk(u_ies_stack_mem.m[10'h2fe], 8'h12);
    apb(1, ADDR_FLAGS, 32'h83);
    ret(IES_OP_OTHER, 16'h0200);
    wpc(16'h0008);
    wpc(16'h0103);
    ret(IES_OP_RETURN_FROM_HANDLER_OP, 16'h0000);
    wpc(16'h0200);
    ret(IES_OP_RETURN_FROM_HANDLER_OP, 16'h0000);
    wpc(16'h1234);
    apb(0, ADDR_FLAGS, 0); chk(rd, 32'h83);
  endtask
  // zero registers give a zero sum, so the zero flag is the only alu flag set beside global enable
  task automatic t_alu_sleep;
    apb(1, ADDR_FLAGS, 32'h80);
    ret(IES_OP_ALU, 16'h0400);
    @(posedge pclk) chk({alu_q, flags_q}, 32'h0082);
    core_sleep <= 1;
    pulse(4'h1, 2'b00);
    repeat (9) @(posedge pclk);
    chk({pc_load, pc_value}, 32'h10002);
    wpc(16'h0100);
    pulse(4'h1, 2'b00);
    ret(IES_OP_RETURN_FROM_HANDLER_OP, 16'h0000);
    repeat (6) @(posedge pclk);
    chk(core_hold, 0);
    core_sleep <= 0;
    apb(1, ADDR_PENDING, 32'h1);
  endtask
  task automatic t_level;
    pulse(4'h0, 2'b01);
    pulse(4'h0, 2'b00);
    apb(1, ADDR_ENABLE, 32'h3f);
    ret(IES_OP_OTHER, 16'h0300);
    @(posedge pclk) chk(core_hold, 0);
    pulse(4'h0, 2'b10);
    ret(IES_OP_CLI, 16'h0302);
    @(posedge pclk) chk(core_hold, 0);
    ret(IES_OP_SEI, 16'h0304);
    ret(IES_OP_OTHER, 16'h0306);
    wpc(16'h000c);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cuts a hang short well past the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_flags();
    t_nest();
    t_alu_sleep();
    t_level();
    tally_and_finish();
  end
endmodule
